// ---- msc_checker.sv ----
`timescale 1ns/1ps

module msc_checker #(
  parameter int unsigned INIT_CYC = msc_pkg::INIT_DEF_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_SELECT_N_OE,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_REQUEST,
  input wire logic FAULT_EVENT,
  input wire logic FLAG_CLEAR,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic BUS_ENABLE,
  input wire logic LOW_POWER_ACTIVE,
  input wire logic PRESENCE_DETECT_N,
  input wire logic PRESENCE_DETECT_OE,
  input wire logic INTERRUPT_N_OUT,
  input wire logic INTERRUPT_N_OE,
  input wire logic INIT_PENDING
);
  logic [3:0]  age_q;
  logic [31:0] pend_q;
  logic        sel_eff;
  // an undriven select pin reads deselected
  assign sel_eff = MODULE_SELECT_N | ~MODULE_SELECT_N_OE;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST) pend_q <= 32'h0000_0000;
    else if (!INIT_PENDING || !MODULE_RESET_N) pend_q <= 32'h0000_0000;
    else pend_q <= pend_q + 32'h0000_0001;
  ////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_bus_follow: assert property (age_q > 4'h3 |-> BUS_ENABLE == !$past(sel_eff, 3))
    else $error("bus enable does not follow select");
  chk_sda_gate: assert property (sel_eff [*5] |-> !SDA_OE)
    else $error("data line driven while deselected");
  chk_lp_follow: assert property (LOW_POWER_REQUEST [*4] |-> LOW_POWER_ACTIVE)
    else $error("low power state not entered");
  chk_open_drain: assert property (!INTERRUPT_N_OUT && !SDA_OUT)
    else $error("open drain output driven high");
  chk_presence_low: assert property (PRESENCE_DETECT_OE && !PRESENCE_DETECT_N)
    else $error("presence not held low");
  chk_fault_int: assert property (FAULT_EVENT |-> ##2 INTERRUPT_N_OE)
    else $error("fault did not assert interrupt");
  chk_clear_release: assert property (FLAG_CLEAR && !FAULT_EVENT && !INIT_PENDING |-> ##2 !INTERRUPT_N_OE)
    else $error("interrupt not released after clear");
  chk_done_int: assert property ($fell(INIT_PENDING) |-> ##1 INTERRUPT_N_OE)
    else $error("completion interrupt missing");
  chk_init_bound: assert property (pend_q <= 32'(INIT_CYC + 8))
    else $error("initialization too long");
  cov_fault: cover property (FAULT_EVENT ##2 INTERRUPT_N_OE);
  cov_done: cover property ($fell(INIT_PENDING));
  cov_select: cover property (BUS_ENABLE && SDA_OE);
endmodule : msc_checker

bind msc_sideband msc_checker #(.INIT_CYC(INIT_CYC)) chk_i (.*);

// ---- msc_host.sv ----
`timescale 1ns/1ps

// host board side: pull-ups make a released line read high
module msc_host (
  input  wire logic int_oe,
  input  wire logic prs_oe,
  input  wire logic prs_drv,
  output logic      int_line,
  output logic      prs_line
);
  assign int_line = int_oe ? 1'b0 : 1'b1;
  assign prs_line = prs_oe ? prs_drv : 1'b1;
endmodule : msc_host

// ---- msc_pkg.sv ----
package msc_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  // minimum reset pulse on the reset pin, in ns
  localparam int unsigned RESET_MIN_NS     = 2000;
  localparam int unsigned RESET_MIN_CYC    = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  // longest management initialization, in ms
  localparam int unsigned INIT_MAX_MS      = 2000;
  localparam longint unsigned INIT_MAX_CYC = longint'(INIT_MAX_MS) * 1000 * CLK_MHZ;
  // longest interrupt release after clear-on-read, in us
  localparam int unsigned INT_OFF_MAX_US   = 500;
  localparam int unsigned INT_OFF_MAX_CYC  = INT_OFF_MAX_US * CLK_MHZ;
  // default init time used by the device (well inside the maximum), in cycles
  localparam int unsigned INIT_DEF_CYC     = 32'h0000_1000;

  localparam int unsigned CNT_W            = 32;

  typedef enum logic [1:0] {
    MSC_ST_RESET,
    MSC_ST_INIT,
    MSC_ST_READY
  } msc_state_t;

endpackage : msc_pkg

// ---- msc_sideband.sv ----
`timescale 1ns/1ps

// What this block does
// - select low lets two-wire bus answer
// - select high: ignore bus, drive nothing
// - undriven select defaults to deselected high
// - long reset pulse restores all default settings
// - reset execution starts at reset rising edge
// - reset done clears init flag, asserts interrupt
// - power-up raises same completion interrupt itself
// - low-power request high enters reduced power
// - presence held low while inserted
// - interrupt low reports fault or critical status
// - interrupt only sunk low or released
// - initialization completes within 2000 ms
// - release interrupt within 500us after clear
module msc_sideband #(
  parameter int unsigned INIT_CYC = msc_pkg::INIT_DEF_CYC
) (
  input  wire logic CORE_CLK,
  input  wire logic RST,
  input  wire logic MODULE_SELECT_N,
  input  wire logic MODULE_SELECT_N_OE,
  input  wire logic MODULE_RESET_N,
  input  wire logic LOW_POWER_REQUEST,
  input  wire logic FAULT_EVENT,
  input  wire logic FLAG_CLEAR,
  input  wire logic SETTINGS_WE,
  input  wire logic [7:0] SETTINGS_D,
  input  wire logic BUS_SDA_OUT,
  input  wire logic BUS_SDA_OE,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  output logic      BUS_ENABLE,
  output logic      LOW_POWER_ACTIVE,
  output logic      PRESENCE_DETECT_N,
  output logic      PRESENCE_DETECT_OE,
  output logic      INTERRUPT_N_OUT,
  output logic      INTERRUPT_N_OE,
  output logic      INIT_PENDING,
  output logic      SETTINGS_VALID,
  output logic [7:0] SETTINGS_Q
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronizers

  logic sel_pin_s;
  logic sel_drv_s;
  logic sel_n_s;
  logic rst_n_s;
  logic lp_s;

  msc_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (MODULE_SELECT_N),
    .q   (sel_pin_s)
  );

  // the drive flag resets low, so the select reads undriven until the host is seen
  msc_sync #(.RESET_VAL(1'b0)) u_sync_sel_drv (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (MODULE_SELECT_N_OE),
    .q   (sel_drv_s)
  );

  // an undriven select reads as high, as the internal pull-up would make it;
  // the two pins meet only after their synchronizers, so no glitch is captured
  assign sel_n_s = sel_pin_s | ~sel_drv_s;

  msc_sync #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (MODULE_RESET_N),
    .q   (rst_n_s)
  );

  msc_sync #(.RESET_VAL(1'b0)) u_sync_lp (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (LOW_POWER_REQUEST),
    .q   (lp_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse qualification

  logic [msc_pkg::CNT_W-1:0] low_cnt_q;
  logic                      long_low_q;
  logic                      rst_n_prev_q;
  logic                      rst_rise;

  assign rst_rise = rst_n_s & ~rst_n_prev_q;

  // resets high like the pin, so no false rising edge follows reset
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rst_n_prev_q <= 1'b1;
    end else begin
      rst_n_prev_q <= rst_n_s;
    end
  end

  // saturating count of synchronized low cycles on the reset pin
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      low_cnt_q <= '0;
    end else if (!rst_n_s) begin
      if (low_cnt_q < msc_pkg::CNT_W'(msc_pkg::RESET_MIN_CYC)) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
    end else begin
      low_cnt_q <= '0;
    end
  end

  // held until the pin rises, so a long pulse is remembered through its low phase
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      long_low_q <= 1'b0;
    end else if (!rst_n_s && low_cnt_q >= msc_pkg::CNT_W'(msc_pkg::RESET_MIN_CYC)) begin
      long_low_q <= 1'b1;
    end else if (rst_rise) begin
      long_low_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // initialization sequence

  msc_pkg::msc_state_t       st_q;
  logic [msc_pkg::CNT_W-1:0] init_cnt_q;
  logic                      done_pulse;

  // short glitches on reset are ignored; only a qualified pulse restarts init
  assign done_pulse = (st_q == msc_pkg::MSC_ST_INIT) &&
                      (init_cnt_q >= msc_pkg::CNT_W'(INIT_CYC));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_q       <= msc_pkg::MSC_ST_INIT;
      init_cnt_q <= '0;
    end else begin
      unique case (st_q)
        msc_pkg::MSC_ST_RESET: begin
          init_cnt_q <= '0;
          if (rst_rise) begin
            st_q <= msc_pkg::MSC_ST_INIT;
          end
        end
        msc_pkg::MSC_ST_INIT: begin
          init_cnt_q <= init_cnt_q + 1'b1;
          if (long_low_q && !rst_n_s) begin
            st_q <= msc_pkg::MSC_ST_RESET;
          end else if (done_pulse) begin
            st_q <= msc_pkg::MSC_ST_READY;
          end
        end
        msc_pkg::MSC_ST_READY: begin
          init_cnt_q <= '0;
          if (long_low_q && !rst_n_s) begin
            st_q <= msc_pkg::MSC_ST_RESET;
          end
        end
        // an illegal code restarts init rather than waiting on a reset edge that may never come
        default: begin
          init_cnt_q <= '0;
          st_q       <= msc_pkg::MSC_ST_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      INIT_PENDING <= 1'b1;
    end else begin
      INIT_PENDING <= (st_q != msc_pkg::MSC_ST_READY) && !done_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user settings, restored to defaults by a qualified reset

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SETTINGS_VALID <= 1'b0;
    end else begin
      SETTINGS_VALID <= (st_q == msc_pkg::MSC_ST_READY);
    end
  end

  // writes outside ready are dropped, so a host cannot race the restore
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SETTINGS_Q <= 8'h00;
    end else if (st_q == msc_pkg::MSC_ST_RESET) begin
      SETTINGS_Q <= 8'h00;
    end else if (SETTINGS_WE && st_q == msc_pkg::MSC_ST_READY) begin
      SETTINGS_Q <= SETTINGS_D;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire bus gating

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      BUS_ENABLE <= 1'b0;
    end else begin
      BUS_ENABLE <= ~sel_n_s;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SDA_OUT    <= 1'b0;
      SDA_OE     <= 1'b0;
    end else begin
      SDA_OUT    <= 1'b0;
      // open drain: only ever pull low, and only while selected
      SDA_OE     <= ~sel_n_s & BUS_SDA_OE & ~BUS_SDA_OUT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low power and presence

  // status only; the power rails themselves are switched outside this block
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      LOW_POWER_ACTIVE <= 1'b0;
    end else begin
      LOW_POWER_ACTIVE <= lp_s;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRESENCE_DETECT_N  <= 1'b0;
      PRESENCE_DETECT_OE <= 1'b1;
    end else begin
      PRESENCE_DETECT_N  <= 1'b0;
      PRESENCE_DETECT_OE <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky causes, open drain output

  logic fault_flag_q;
  logic done_flag_q;

  // a new event in the clear cycle wins over the clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      fault_flag_q <= 1'b0;
    end else if (FAULT_EVENT) begin
      fault_flag_q <= 1'b1;
    end else if (FLAG_CLEAR) begin
      fault_flag_q <= 1'b0;
    end
  end

  // a running reset also drops a stale completion, so the next one is reported afresh
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      done_flag_q <= 1'b0;
    end else if (done_pulse) begin
      done_flag_q <= 1'b1;
    end else if (FLAG_CLEAR || st_q == msc_pkg::MSC_ST_RESET) begin
      done_flag_q <= 1'b0;
    end
  end

  // release lands two cycles after the clear, far inside the allowed window
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      INTERRUPT_N_OUT <= 1'b0;
      INTERRUPT_N_OE  <= 1'b0;
    end else begin
      INTERRUPT_N_OUT <= 1'b0;
      INTERRUPT_N_OE  <= fault_flag_q | done_flag_q;
    end
  end

endmodule : msc_sideband

// ---- msc_sideband_tb.sv ----
`timescale 1ns/1ps

module msc_sideband_tb;
  logic clk = 1'b0, rst = 1'b1, sel_n = 1'b1, sel_oe = 1'b0, rpin = 1'b1, lp = 1'b0;
  logic flt = 1'b0, fclr = 1'b0, swe = 1'b0, bsda = 1'b0, bsda_oe = 1'b0;
  logic [7:0] sd = 8'h00;
  wire logic sda_o, sda_oe, bus_en, lpa, prs_n, prs_oe, int_o, int_oe, pend, sval, int_line, prs_line;
  wire logic [7:0] sq;
  int error_cnt = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  msc_sideband #(.INIT_CYC(16)) dut (.CORE_CLK(clk), .RST(rst), .MODULE_SELECT_N(sel_n),
    .MODULE_SELECT_N_OE(sel_oe), .MODULE_RESET_N(rpin), .LOW_POWER_REQUEST(lp), .FAULT_EVENT(flt),
    .FLAG_CLEAR(fclr), .SETTINGS_WE(swe), .SETTINGS_D(sd), .BUS_SDA_OUT(bsda), .BUS_SDA_OE(bsda_oe),
    .SDA_OUT(sda_o), .SDA_OE(sda_oe), .BUS_ENABLE(bus_en), .LOW_POWER_ACTIVE(lpa),
    .PRESENCE_DETECT_N(prs_n), .PRESENCE_DETECT_OE(prs_oe), .INTERRUPT_N_OUT(int_o),
    .INTERRUPT_N_OE(int_oe), .INIT_PENDING(pend), .SETTINGS_VALID(sval), .SETTINGS_Q(sq));
  msc_host host (.int_oe(int_oe), .prs_oe(prs_oe), .prs_drv(prs_n), .int_line(int_line), .prs_line(prs_line));
  ////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  // settle past the edge so the flops have updated before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_done(input int lim);
    int i;
    for (i = 0; i < lim && pend !== 1'b0; i++) cyc(1);
    if (pend !== 1'b0) begin
      error_cnt++;
      $display("Error at %0t: init never finished", $time);
      conclude();
    end
    cyc(2);
  endtask : wait_done
  ////////////////////////////////////////
  task automatic t_power();
    chk(pend === 1'b1 && int_line === 1'b1, "init not pending");
    wait_done(60);
    chk(int_line === 1'b0 && sval === 1'b1 && sq === 8'h00, "no power-up interrupt");
    chk(prs_line === 1'b0, "presence not low");
  endtask : t_power
  task automatic t_select();
    @(posedge clk) bsda_oe <= 1'b1;
    cyc(6);
    chk(bus_en === 1'b0 && sda_oe === 1'b0, "undriven select answered");
    @(posedge clk) {sel_oe, sel_n} <= 2'b10;
    cyc(6);
    chk(bus_en === 1'b1 && sda_oe === 1'b1, "selected module silent");
    @(posedge clk) sel_n <= 1'b1;
    cyc(6);
    chk(bus_en === 1'b0 && sda_oe === 1'b0 && sda_o === 1'b0, "deselected module drove bus");
  endtask : t_select
  task automatic t_irq();
    @(posedge clk) fclr <= 1'b1;
    @(posedge clk) fclr <= 1'b0;
    cyc(3);
    chk(int_line === 1'b1, "interrupt kept after clear");
    @(posedge clk) flt <= 1'b1;
    @(posedge clk) flt <= 1'b0;
    cyc(2);
    chk(int_line === 1'b0, "fault not reported");
    @(posedge clk) fclr <= 1'b1;
    @(posedge clk) fclr <= 1'b0;
    cyc(3);
    chk(int_line === 1'b1, "fault interrupt not released");
  endtask : t_irq
  task automatic t_lp();
    @(posedge clk) lp <= 1'b1;
    cyc(5);
    chk(lpa === 1'b1, "low power not entered");
    @(posedge clk) lp <= 1'b0;
    cyc(5);
    chk(lpa === 1'b0, "low power not left");
  endtask : t_lp
  task automatic t_reset();
    @(posedge clk) {swe, sd} <= {1'b1, 8'h5a};
    @(posedge clk) swe <= 1'b0;
    @(posedge clk) rpin <= 1'b0;
    cyc(20);
    @(posedge clk) rpin <= 1'b1;
    cyc(6);
    chk(sq === 8'h5a && pend === 1'b0, "short pulse acted");
    @(posedge clk) rpin <= 1'b0;
    cyc(410);
    chk(sq === 8'h00 && pend === 1'b1 && int_line === 1'b1, "long pulse no reset");
    @(posedge clk) rpin <= 1'b1;
    wait_done(40);
    chk(int_line === 1'b0 && sval === 1'b1, "no reset completion interrupt");
  endtask : t_reset
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    t_power();
    t_select();
    t_irq();
    t_lp();
    t_reset();
    conclude();
  end
endmodule : msc_sideband_tb

// ---- msc_sync.sv ----
`timescale 1ns/1ps

// two-stage synchronizer; first stage is read only by the second
module msc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      q      <= RESET_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : msc_sync
